// File: hdl/tcc_timer.sv
// Purpose: 16-bit timer with two captures, two compares, forcing and single pulse
// Assumes: classic Wishbone slave, byte registers in data bits 7:0
// Notes:   cpu_irq_mask_i is the processor's global interrupt mask
//
// Operation
// - active capture pin edge copies the counter into that capture register
// - one edge-select bit per capture pin picks rising or falling
// - capture sets its flag; interrupt when enabled and cpu mask clear
// - capture flag clears by status read then capture low byte access
// - capture high read blocks captures and flag until low byte read, except flag one set by pwm wrap
// - capture register always holds the newest capture value
// - capture inputs always connected; any qualifying edge captures
// - single pulse and pwm modes: only capture channel two captures
// - both compare registers compared with counter every timer tick
// - match sets compare flag, drives level if enabled, may interrupt
// - compare registers read/write, untouched by hardware, reset 8000h
// - compare pin latches are low while reset is active
// - compare flag clears by status read then compare low byte access
// - compare high write stops matching until compare low write
// - output enable clear: pin not driven, match may still interrupt
// - flag and pin update during the counter state equal to compare
// - force bit copies level to pin if enabled, no flag; ignored in pulse/pwm
// - single pulse bit uses capture one trigger, compare one timing
// - pulse trigger: counter FFFCh, level two out, flag one, capture FFFDh
// - pulse mode match on compare one drives level one, ending pulse
// - pulse mode never sets compare flag one; channel two pinless
// - pwm and single pulse both set means pwm only
// - counter starts at FFFCh after reset and counter low write
// - clock select: cpu clock over 2, 4, 8, or external pin
`timescale 1ns/100ps
`default_nettype none
module tcc_timer (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   input  wire logic                          we_i,
   input  wire logic [tcc_pkg::TCC_ADR_W-1:0] adr_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic [31:0]                   dat_i,
   output logic      [31:0]                   dat_o,
   output logic                               ack_o,
   input  wire logic                          cpu_irq_mask_i,
   input  wire logic [1:0]                    capture_pin_i,
   input  wire logic                          external_timer_clock_pin_i,
   output logic      [1:0]                    compare_pin_o,
   output logic      [1:0]                    compare_pin_oe_o,
   output logic                               timer_irq_o
);
   import tcc_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   tcc_control_one_type  ctrl1_q;
   tcc_control_one_type  ctrl1_wr;
   tcc_control_two_type  ctrl2_q;
   tcc_timer_status_type status_rd;
   logic [15:0]          cnt_q;
   logic [15:0]          cnt_d;
   logic                 cnt_new_q;
   logic [2:0]           presc_q;
   logic [15:0]          cap_q [2];
   logic [15:0]          cmp_q [2];
   logic [1:0]           cap_inh_q;
   logic [1:0]           cmp_arm_q;
   logic [1:0]           icf_q;
   logic [1:0]           icf_d;
   logic [1:0]           icf_arm_q;
   logic [1:0]           ocf_q;
   logic [1:0]           ocf_d;
   logic [1:0]           ocf_arm_q;
   logic                 wrap_flag_q;
   logic                 wrap_arm_q;
   logic [7:0]           cnt_buf_q;
   logic                 cnt_buf_vld_q;
   logic [1:0]           pin_q;
   logic [1:0]           pin_d;
   logic                 ack_q;
   logic [7:0]           rd_byte_q;
   logic [7:0]           rd_byte;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire acc = cyc_i & stb_i & ~ack_q;
   wire wr  = acc & we_i & sel_i[0];
   wire rd  = acc & ~we_i;

   // request passed as an argument: a net read only inside the function
   // would not wake the continuous assignments that call it
   wire [8:0] req = {acc, adr_i};

   function automatic logic hit(input logic [8:0] rq, input logic [7:0] off);
      hit = rq[8] && (rq[7:0] == off);
   endfunction

   wire        wr_ctrl1  = wr & hit(req, TCC_OFF_CTRL1);
   wire        wr_ctrl2  = wr & hit(req, TCC_OFF_CTRL2);
   wire        rd_status = rd & hit(req, TCC_OFF_STATUS);
   wire [1:0]  rd_cap_hi = {rd & hit(req, TCC_OFF_CAP2_HI), rd & hit(req, TCC_OFF_CAP1_HI)};
   wire [1:0]  rd_cap_lo = {rd & hit(req, TCC_OFF_CAP2_LO), rd & hit(req, TCC_OFF_CAP1_LO)};
   wire [1:0]  ac_cap_lo = {hit(req, TCC_OFF_CAP2_LO), hit(req, TCC_OFF_CAP1_LO)};
   wire [1:0]  wr_cmp_hi = {wr & hit(req, TCC_OFF_CMP2_HI), wr & hit(req, TCC_OFF_CMP1_HI)};
   wire [1:0]  wr_cmp_lo = {wr & hit(req, TCC_OFF_CMP2_LO), wr & hit(req, TCC_OFF_CMP1_LO)};
   wire [1:0]  ac_cmp_lo = {hit(req, TCC_OFF_CMP2_LO), hit(req, TCC_OFF_CMP1_LO)};
   wire        ac_cnt_lo = hit(req, TCC_OFF_CNT_LO);
   wire        rd_cnt_hi = rd & (hit(req, TCC_OFF_CNT_HI) | hit(req, TCC_OFF_ALT_HI));
   wire        rd_cnt_lo = rd & (hit(req, TCC_OFF_CNT_LO) | hit(req, TCC_OFF_ALT_LO));
   wire        wr_cnt_lo = wr & (hit(req, TCC_OFF_CNT_LO) | hit(req, TCC_OFF_ALT_LO));

   // ---------------------------------------------------------------
   // modes
   // ---------------------------------------------------------------
   wire pwm = ctrl2_q.pwm_select;
   wire pulse = ctrl2_q.single_pulse_select & ~pwm;
   wire spc = pulse | pwm;

   // force bits never stored; they act only on the writing cycle
   assign ctrl1_wr = tcc_control_one_type'(dat_i[7:0]);

   // ---------------------------------------------------------------
   // pin edges
   // ---------------------------------------------------------------
   logic [1:0] cap_ev;
   logic       ext_ev;

   tcc_edge_sync u_cap1 (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .pin_i        (capture_pin_i[0]),
      .rising_sel_i (ctrl1_q.capture_edge_select1),
      .event_o      (cap_ev[0])
   );

   tcc_edge_sync u_cap2 (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .pin_i        (capture_pin_i[1]),
      .rising_sel_i (ctrl2_q.capture_edge_select2),
      .event_o      (cap_ev[1])
   );

   tcc_edge_sync u_ext (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .pin_i        (external_timer_clock_pin_i),
      .rising_sel_i (ctrl2_q.ext_clock_edge_select),
      .event_o      (ext_ev)
   );

   // ---------------------------------------------------------------
   // timer clock and counter
   // ---------------------------------------------------------------
   logic [2:0] div_mask;
   logic       tick;

   always_comb begin
      div_mask = TCC_DIV8_MASK;
      unique case (ctrl2_q.timer_clock_select)
         TCC_CLK_DIV2: div_mask = TCC_DIV2_MASK;
         TCC_CLK_DIV4: div_mask = TCC_DIV4_MASK;
         TCC_CLK_DIV8: div_mask = TCC_DIV8_MASK;
         TCC_CLK_EXT:  div_mask = TCC_DIV8_MASK;
      endcase
   end

   assign tick = (ctrl2_q.timer_clock_select == TCC_CLK_EXT) ? ext_ev
               : ((presc_q & div_mask) == div_mask);

   logic [1:0] cmp_eq;
   wire        pulse_trig = pulse & cap_ev[0];
   wire        pulse_load = pulse_trig & ~cap_inh_q[0];
   wire        pwm_wrap   = pwm & cmp_eq[1];
   wire        reload     = wr_cnt_lo | pulse_trig | pwm_wrap;
   wire        wrap       = tick & ~reload & (cnt_q == TCC_CNT_TOP);

   assign cnt_d = reload ? TCC_CNT_RESET
                : tick   ? cnt_q + 16'h0001
                : cnt_q;

   // ---------------------------------------------------------------
   // compare matching, one event per counter state
   // ---------------------------------------------------------------
   // a match is evaluated only in the cycle after the counter moved, so a
   // flag cleared while the counter dwells on the value is not set again
   assign cmp_eq[0] = cnt_new_q & cmp_arm_q[0] & (cnt_q == cmp_q[0]);
   assign cmp_eq[1] = cnt_new_q & cmp_arm_q[1] & (cnt_q == cmp_q[1]);
   wire [1:0] ocf_set = {cmp_eq[1] & ~pwm, cmp_eq[0] & ~spc};

   // ---------------------------------------------------------------
   // capture qualification
   // ---------------------------------------------------------------
   wire [1:0] cap_ok  = {cap_ev[1] & ~cap_inh_q[1], cap_ev[0] & ~cap_inh_q[0] & ~spc};
   wire [1:0] icf_set = {cap_ok[1], cap_ok[0] | pulse_load | pwm_wrap};

   // ---------------------------------------------------------------
   // flags: set wins over clear
   // ---------------------------------------------------------------
   wire [1:0] icf_clr = icf_arm_q & ac_cap_lo;
   wire [1:0] ocf_clr = ocf_arm_q & ac_cmp_lo;
   wire       wrap_clr = wrap_arm_q & ac_cnt_lo;

   assign icf_d = icf_set | (icf_q & ~icf_clr);
   assign ocf_d = ocf_set | (ocf_q & ~ocf_clr);

   // ---------------------------------------------------------------
   // compare pin latches
   // ---------------------------------------------------------------
   wire       force_ok = wr_ctrl1 & ~spc;
   wire [1:0] lvl_now  = {ctrl1_q.compare_output_level2, ctrl1_q.compare_output_level1};
   wire [1:0] lvl_wr   = {ctrl1_wr.compare_output_level2, ctrl1_wr.compare_output_level1};
   wire [1:0] force_on = {force_ok & ctrl1_wr.force_output_level2,
                          force_ok & ctrl1_wr.force_output_level1};
   wire [1:0] oe       = {ctrl2_q.compare_output_enable2, ctrl2_q.compare_output_enable1};

   always_comb begin
      pin_d = pin_q;
      if (pwm) begin
         if (oe[0] && cmp_eq[1]) begin
            pin_d[0] = lvl_now[1];
         end else if (oe[0] && cmp_eq[0]) begin
            pin_d[0] = lvl_now[0];
         end
      end else if (pulse) begin
         if (oe[0] && pulse_trig) begin
            pin_d[0] = lvl_now[1];
         end else if (oe[0] && cmp_eq[0]) begin
            pin_d[0] = lvl_now[0];
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (oe[i] && force_on[i]) begin
               pin_d[i] = lvl_wr[i];
            end else if (oe[i] && cmp_eq[i]) begin
               pin_d[i] = lvl_now[i];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   assign status_rd = '{capture_flag1:     icf_q[0],
                        compare_flag1:     ocf_q[0],
                        counter_wrap_flag: wrap_flag_q,
                        capture_flag2:     icf_q[1],
                        compare_flag2:     ocf_q[1],
                        unused:            3'h0};

   wire [7:0] cnt_lo_view = cnt_buf_vld_q ? cnt_buf_q : cnt_q[7:0];

   always_comb begin
      rd_byte = 8'h00;
      unique case (adr_i)
         TCC_OFF_CTRL1:   rd_byte = ctrl1_q;
         TCC_OFF_CTRL2:   rd_byte = ctrl2_q;
         TCC_OFF_STATUS:  rd_byte = status_rd;
         TCC_OFF_CAP1_HI: rd_byte = cap_q[0][15:8];
         TCC_OFF_CAP1_LO: rd_byte = cap_q[0][7:0];
         TCC_OFF_CMP1_HI: rd_byte = cmp_q[0][15:8];
         TCC_OFF_CMP1_LO: rd_byte = cmp_q[0][7:0];
         TCC_OFF_CAP2_HI: rd_byte = cap_q[1][15:8];
         TCC_OFF_CAP2_LO: rd_byte = cap_q[1][7:0];
         TCC_OFF_CMP2_HI: rd_byte = cmp_q[1][15:8];
         TCC_OFF_CMP2_LO: rd_byte = cmp_q[1][7:0];
         TCC_OFF_CNT_HI:  rd_byte = cnt_q[15:8];
         TCC_OFF_CNT_LO:  rd_byte = cnt_lo_view;
         TCC_OFF_ALT_HI:  rd_byte = cnt_q[15:8];
         TCC_OFF_ALT_LO:  rd_byte = cnt_lo_view;
         default:         rd_byte = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // bus and control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q     <= 1'b0;
         rd_byte_q <= 8'h00;
         ctrl1_q   <= tcc_control_one_type'(TCC_CTRL_RESET);
         ctrl2_q   <= tcc_control_two_type'(TCC_CTRL_RESET);
      end else begin
         ack_q     <= acc;
         rd_byte_q <= rd ? rd_byte : 8'h00;
         if (wr_ctrl1) begin
            ctrl1_q                     <= ctrl1_wr;
            ctrl1_q.force_output_level1 <= 1'b0;
            ctrl1_q.force_output_level2 <= 1'b0;
         end
         if (wr_ctrl2) begin
            ctrl2_q <= tcc_control_two_type'(dat_i[7:0]);
         end
      end
   end

   // ---------------------------------------------------------------
   // counter, prescaler and read buffer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q         <= TCC_CNT_RESET;
         cnt_new_q     <= 1'b1;
         presc_q       <= 3'h0;
         cnt_buf_q     <= 8'h00;
         cnt_buf_vld_q <= 1'b0;
      end else begin
         cnt_q     <= cnt_d;
         cnt_new_q <= reload | tick;
         presc_q   <= presc_q + 3'h1;
         // high byte read freezes the low byte until the low byte is read
         if (rd_cnt_hi && !cnt_buf_vld_q) begin
            cnt_buf_q     <= cnt_q[7:0];
            cnt_buf_vld_q <= 1'b1;
         end else if (rd_cnt_lo) begin
            cnt_buf_vld_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // capture and compare registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_q[0]  <= 16'h0000;
         cap_q[1]  <= 16'h0000;
         cmp_q[0]  <= TCC_CMP_RESET;
         cmp_q[1]  <= TCC_CMP_RESET;
         cap_inh_q <= 2'b00;
         cmp_arm_q <= 2'b11;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cap_ok[i]) begin
               cap_q[i] <= cnt_q;
            end
            if (wr_cmp_hi[i]) begin
               cmp_q[i][15:8] <= dat_i[7:0];
               cmp_arm_q[i]   <= 1'b0;
            end
            if (wr_cmp_lo[i]) begin
               cmp_q[i][7:0] <= dat_i[7:0];
               cmp_arm_q[i]  <= 1'b1;
            end
            if (rd_cap_hi[i]) begin
               cap_inh_q[i] <= 1'b1;
            end else if (rd_cap_lo[i]) begin
               cap_inh_q[i] <= 1'b0;
            end
         end
         if (pulse_load) begin
            cap_q[0] <= TCC_CAP_PULSE;
         end
      end
   end

   // ---------------------------------------------------------------
   // flags, clear arming and pin latches
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         icf_q     <= 2'b00;
         ocf_q     <= 2'b00;
         wrap_flag_q <= 1'b0;
         icf_arm_q   <= 2'b00;
         ocf_arm_q   <= 2'b00;
         wrap_arm_q  <= 1'b0;
         pin_q     <= 2'b00;
      end else begin
         icf_q <= icf_d;
         ocf_q <= ocf_d;
         wrap_flag_q <= wrap | (wrap_flag_q & ~wrap_clr);
         pin_q <= pin_d;
         // the status read arms exactly the flags that were set when read
         if (rd_status) begin
            icf_arm_q <= icf_q;
            ocf_arm_q <= ocf_q;
            wrap_arm_q <= wrap_flag_q;
         end else begin
            icf_arm_q <= icf_arm_q & ~ac_cap_lo;
            ocf_arm_q <= ocf_arm_q & ~ac_cmp_lo;
            wrap_arm_q <= wrap_arm_q & ~ac_cnt_lo;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign ack_o            = ack_q;
   assign dat_o            = {24'h000000, rd_byte_q};
   assign compare_pin_o    = pin_q;
   // in single pulse and pwm modes channel two never drives its pin
   assign compare_pin_oe_o = {oe[1] & ~spc, oe[0]};

   // request stays pending in the flags until unmasked
   assign timer_irq_o = ~cpu_irq_mask_i &
                        ((ctrl1_q.capture_irq_enable & (|icf_q)) |
                         (ctrl1_q.compare_irq_enable & (|ocf_q)) |
                         (ctrl1_q.wrap_irq_enable & wrap_flag_q));
endmodule
`default_nettype wire

// File: shared/tcc_pkg.sv
// Purpose: shared constants and types of the timer capture/compare block
// Assumes: byte-wide registers, one per aligned 32-bit Wishbone word
// Notes:   offsets are byte addresses; data sits in bits 7:0
package tcc_pkg;

   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int unsigned TCC_ADR_W = 8;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] TCC_OFF_CTRL1   = 8'h00;
   localparam logic [7:0] TCC_OFF_CTRL2   = 8'h04;
   localparam logic [7:0] TCC_OFF_STATUS  = 8'h08;
   localparam logic [7:0] TCC_OFF_CAP1_HI = 8'h0C;
   localparam logic [7:0] TCC_OFF_CAP1_LO = 8'h10;
   localparam logic [7:0] TCC_OFF_CMP1_HI = 8'h14;
   localparam logic [7:0] TCC_OFF_CMP1_LO = 8'h18;
   localparam logic [7:0] TCC_OFF_CAP2_HI = 8'h1C;
   localparam logic [7:0] TCC_OFF_CAP2_LO = 8'h20;
   localparam logic [7:0] TCC_OFF_CMP2_HI = 8'h24;
   localparam logic [7:0] TCC_OFF_CMP2_LO = 8'h28;
   localparam logic [7:0] TCC_OFF_CNT_HI  = 8'h2C;
   localparam logic [7:0] TCC_OFF_CNT_LO  = 8'h30;
   localparam logic [7:0] TCC_OFF_ALT_HI  = 8'h34;
   localparam logic [7:0] TCC_OFF_ALT_LO  = 8'h38;

   // ---------------------------------------------------------------
   // reset and load values
   // ---------------------------------------------------------------
   localparam logic [15:0] TCC_CNT_RESET  = 16'hFFFC;
   localparam logic [15:0] TCC_CAP_PULSE  = 16'hFFFD;
   localparam logic [15:0] TCC_CNT_TOP    = 16'hFFFF;
   localparam logic [15:0] TCC_CMP_RESET  = 16'h8000;
   localparam logic [7:0]  TCC_CTRL_RESET = 8'h00;

   // ---------------------------------------------------------------
   // prescaler: tick when the masked divider count is all ones
   // ---------------------------------------------------------------
   localparam logic [2:0] TCC_DIV2_MASK = 3'h1;
   localparam logic [2:0] TCC_DIV4_MASK = 3'h3;
   localparam logic [2:0] TCC_DIV8_MASK = 3'h7;

   typedef enum logic [1:0] {
      TCC_CLK_DIV2 = 2'b00,
      TCC_CLK_DIV4 = 2'b01,
      TCC_CLK_DIV8 = 2'b10,
      TCC_CLK_EXT  = 2'b11
   } tcc_clk_sel_type;

   // ---------------------------------------------------------------
   // control register layouts, bit 7 first
   // ---------------------------------------------------------------
   typedef struct packed {
      logic capture_irq_enable;
      logic compare_irq_enable;
      logic wrap_irq_enable;
      logic force_output_level2;
      logic force_output_level1;
      logic compare_output_level2;
      logic compare_output_level1;
      logic capture_edge_select1;
   } tcc_control_one_type;

   typedef struct packed {
      logic            compare_output_enable1;
      logic            compare_output_enable2;
      logic            single_pulse_select;
      logic            pwm_select;
      tcc_clk_sel_type timer_clock_select;
      logic            ext_clock_edge_select;
      logic            capture_edge_select2;
   } tcc_control_two_type;

   typedef struct packed {
      logic       capture_flag1;
      logic       compare_flag1;
      logic       counter_wrap_flag;
      logic       capture_flag2;
      logic       compare_flag2;
      logic [2:0] unused;
   } tcc_timer_status_type;

endpackage

// File: hdl/tcc_edge_sync.sv
// Purpose: synchronise one timer pin and flag its selected edge
// Assumes: pin may change at any time relative to clk_i
// Notes:   event is one clk_i cycle wide, two edges after the pin moves
`timescale 1ns/100ps
`default_nettype none
module tcc_edge_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   input  wire logic rising_sel_i,
   output logic      event_o
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // ---------------------------------------------------------------
   // two-flop synchroniser, then edge history
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // only the second stage and its history feed the detector
   assign event_o = rising_sel_i ? (sync_q & ~last_q) : (~sync_q & last_q);
endmodule
`default_nettype wire

// File: bench/tcc_props.sv
// Purpose: port checker for tcc_timer
// Assumes: one clock, synchronous reset
// Notes:   bound to every tcc_timer below
`timescale 1ns/100ps
`default_nettype none
module tcc_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        cpu_irq_mask_i,
   input wire logic [1:0]  compare_pin_o,
   input wire logic [1:0]  compare_pin_oe_o,
   input wire logic        timer_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_ans; ack_o ##1 !ack_o; endsequence
   a_bus_answer: assert property (s_req |=> s_ans)
      else $error("access not answered by one ack");
   a_idle_data: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data while idle");
   a_upper_zero: assert property (dat_o[31:8] == 24'h0)
      else $error("upper read data set");
   a_reset_pins: assert property (disable iff (1'b0) rst_i |=> compare_pin_o == 2'h0)
      else $error("pin latch not low in reset");
   a_reset_oe: assert property (disable iff (1'b0) rst_i |=> compare_pin_oe_o == 2'h0)
      else $error("pin driven in reset");
   a_irq_reset: assert property (disable iff (1'b0) rst_i |=> !timer_irq_o)
      else $error("request in reset");
   a_mask_irq: assert property (cpu_irq_mask_i |-> !timer_irq_o)
      else $error("request while masked");
   a_oe_by_write: assert property ($rose(compare_pin_oe_o[0]) |-> ack_o)
      else $error("enable rose without write");
endmodule
bind tcc_timer tcc_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
   .cpu_irq_mask_i, .compare_pin_o, .compare_pin_oe_o, .timer_irq_o);
`default_nettype wire

// File: bench/tcc_pins.sv
// Purpose: signal sources and loads on the timer pins
// Assumes: compare pads carry a pull-down
// Notes:   source levels change just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module tcc_pins (
   input  wire logic       clk_i,
   input  wire logic [1:0] level_i,
   input  wire logic [1:0] compare_pin_i,
   input  wire logic [1:0] oe_i,
   output logic      [1:0] capture_pin_o,
   output wire logic [1:0] pad_o
);
   always_ff @(posedge clk_i) capture_pin_o <= level_i;
   // undriven pad falls to the pull-down, never keeps the old level
   assign pad_o = compare_pin_i & oe_i;
endmodule
`default_nettype wire

// File: bench/tb.sv
// Purpose: self-checking bench for tcc_timer
// Assumes: ack comes for every address
// Notes:   pads are read through the pin model
`timescale 1ns/100ps
`default_nettype none
module tb;
   import tcc_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mask = 0;
   logic [7:0] adr = 8'h00, d;
   logic [31:0] dat = 32'h0, dat_o;
   logic ack;
   logic [1:0] lvl = 2'h0, cap, pin, oe, pad;
   logic irq, ext = 0;
   int fail_count = 0, samples_checked = 0;
   always #12.5 clk_i = ~clk_i;
   tcc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
      .cpu_irq_mask_i(mask), .capture_pin_i(cap), .external_timer_clock_pin_i(ext),
      .compare_pin_o(pin), .compare_pin_oe_o(oe), .timer_irq_o(irq));
   tcc_pins u_pins (.clk_i(clk_i), .level_i(lvl), .compare_pin_i(pin), .oe_i(oe),
      .capture_pin_o(cap), .pad_o(pad));
   task automatic print_verdict;
      if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // one classic cycle; the request stands until ack is sampled high
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= {24'h0, v};
      do @(posedge clk_i); while (ack !== 1'b1);
      d = dat_o[7:0];
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      acc(0, a, 8'h00);
      chk($sformatf("reg %h", a), e, d & m);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      print_verdict;
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      rc(TCC_OFF_CMP1_HI, 8'hFF, 8'h80);
      rc(TCC_OFF_CMP2_LO, 8'hFF, 8'h00);
      rc(8'hFC, 8'hFF, 8'h00);
      acc(1, TCC_OFF_CTRL2, 8'h80);
      acc(1, TCC_OFF_CMP1_HI, 8'hFF);
      acc(1, TCC_OFF_CTRL1, 8'h4A);
      acc(1, TCC_OFF_CTRL1, 8'h40);
      chk("forced pad", 8'h01, {7'h0, pad[0]});
      rc(TCC_OFF_STATUS, 8'h40, 8'h00);
      rc(TCC_OFF_CMP1_HI, 8'hFF, 8'hFF);
      acc(1, TCC_OFF_CMP1_LO, 8'hFE);
      acc(1, TCC_OFF_CNT_LO, 8'h00);
      repeat (30) @(posedge clk_i);
      chk("match pad", 8'h00, {7'h0, pad[0]});
      chk("irq", 8'h01, {7'h0, irq});
      mask <= 1;
      @(posedge clk_i);
      #1 chk("masked irq", 8'h00, {7'h0, irq});
      mask <= 0;
      acc(1, TCC_OFF_CTRL2, 8'hA0);
      acc(1, TCC_OFF_CTRL1, 8'h05);
      rc(TCC_OFF_STATUS, 8'h40, 8'h40);
      acc(1, TCC_OFF_CMP1_HI, 8'h00);
      acc(1, TCC_OFF_CMP1_LO, 8'h10);
      rc(TCC_OFF_STATUS, 8'h40, 8'h00);
      lvl <= 2'h1;
      repeat (8) @(posedge clk_i);
      chk("pulse pad", 8'h01, {7'h0, pad[0]});
      rc(TCC_OFF_STATUS, 8'h80, 8'h80);
      rc(TCC_OFF_CAP1_HI, 8'hFF, 8'hFF);
      rc(TCC_OFF_CAP1_LO, 8'hFF, 8'hFD);
      rc(TCC_OFF_STATUS, 8'h80, 8'h00);
      repeat (60) @(posedge clk_i);
      chk("pulse end pad", 8'h00, {7'h0, pad[0]});
      rc(TCC_OFF_STATUS, 8'h40, 8'h00);
      acc(1, TCC_OFF_CTRL2, 8'h0E);
      acc(1, TCC_OFF_CNT_LO, 8'h00);
      repeat (3) begin
         ext <= 1;
         repeat (4) @(posedge clk_i);
         ext <= 0;
         repeat (4) @(posedge clk_i);
      end
      rc(TCC_OFF_CNT_HI, 8'hFF, 8'hFF);
      rc(TCC_OFF_CNT_LO, 8'hFF, 8'hFF);
      lvl <= 2'h3;
      repeat (8) @(posedge clk_i);
      rc(TCC_OFF_STATUS, 8'h10, 8'h00);
      lvl <= 2'h1;
      repeat (8) @(posedge clk_i);
      rc(TCC_OFF_STATUS, 8'h10, 8'h10);
      rc(TCC_OFF_CAP2_HI, 8'hFF, 8'hFF);
      rc(TCC_OFF_CAP2_LO, 8'hFF, 8'hFF);
      print_verdict;
   end
endmodule
`default_nettype wire
